// *** rtl/cgm_pkg.sv ***
// Package for the clock generator mode control block
package cgm_pkg;

  // Timing, in their own units
  localparam longint CLK_HZ       = 200_000_000;
  localparam longint CLK_NS       = 5;
  localparam longint SLOW_REF_HZ  = 243_000;
  localparam longint FAST_REF_HZ  = 8_000_000;
  localparam longint RTI_HZ       = 1_000;
  localparam longint REF_LOSS_NS  = 40_000;
  localparam longint LOOP_MIN_HZ  = 8_000_000;
  localparam longint LOOP_MAX_HZ  = 40_000_000;
  localparam longint PHASE_SPAN   = 65_536;

  // Derived cycle counts and filter limits
  localparam longint SLOW_REF_CYC = CLK_HZ / SLOW_REF_HZ;
  localparam longint FAST_REF_CYC = CLK_HZ / FAST_REF_HZ;
  localparam longint RTI_CYC      = CLK_HZ / RTI_HZ / 2;
  localparam longint REF_LOSS_CYC = (REF_LOSS_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] FILTER_MIN = 16'((LOOP_MIN_HZ * PHASE_SPAN + CLK_HZ - 1) / CLK_HZ);
  localparam logic [15:0] FILTER_MAX = 16'((LOOP_MAX_HZ * PHASE_SPAN) / CLK_HZ);

  // Register byte offsets
  localparam logic [7:0] CTRL1_OFFSET  = 8'h00;
  localparam logic [7:0] CTRL2_OFFSET  = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] FILTER_OFFSET = 8'h0C;
  localparam logic [7:0] TRIM_OFFSET   = 8'h10;

  // Control 1 fields
  localparam int C1_HIGH_GAIN = 7;
  localparam int C1_RANGE     = 6;
  localparam int C1_REF_SEL   = 5;
  localparam int C1_MODE_LSB  = 3;
  localparam int C1_OSC_STOP  = 2;
  localparam int C1_LOC_DIS   = 1;
  // Control 2 fields
  localparam int C2_DIV_LSB   = 0;
  localparam int C2_DBG_FAST  = 3;
  localparam int C2_LOSS_RST  = 4;
  localparam int C2_MULT_LSB  = 8;
  // Status fields
  localparam int ST_LOCKED    = 0;
  localparam int ST_LOST_LOCK = 1;
  localparam int ST_LOSS_CLK  = 2;
  localparam int ST_REF_OK    = 3;
  localparam int ST_STATE_LSB = 8;

  // Reset values and loop tuning
  localparam logic [15:0] FILTER_RESET = 16'h0C00;
  localparam logic [7:0]  TRIM_RESET   = 8'h80;
  localparam logic [7:0]  MULT_RESET   = 8'h40;
  localparam logic [15:0] FILTER_STEP  = 16'h0010;
  localparam logic [9:0]  LOCK_TOL     = 10'h002;
  localparam logic [3:0]  LOCK_WINDOWS = 4'h4;

  typedef enum logic [1:0] {
    CGM_SEL_SELF     = 2'b00,
    CGM_SEL_LOOP_INT = 2'b01,
    CGM_SEL_BYPASS   = 2'b10,
    CGM_SEL_LOOP_EXT = 2'b11
  } cgm_mode_sel_t;

  typedef enum logic [2:0] {
    CGM_OFF      = 3'b000,
    CGM_SELF     = 3'b001,
    CGM_INT_UNLK = 3'b010,
    CGM_INT_LOCK = 3'b011,
    CGM_BYPASS   = 3'b100,
    CGM_EXT_UNLK = 3'b101,
    CGM_EXT_LOCK = 3'b110
  } cgm_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } cgm_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } cgm_apb_rsp_t;

endpackage : cgm_pkg

// *** rtl/cgm_clock_generator.sv ***
// Clock generator mode control with APB register access
// Summary of operation
// R1: Reset enters self-clocked mode at once, no external reference needed.
// R2: Off mode holds the generator output clock static.
// R3: Self-clocked mode free-runs the oscillator at the filter setting.
// R4: Loop internal mode targets a programmable multiple of the internal reference.
// R5: Off-target engaged mode stays unlocked and keeps adjusting the oscillator.
// R6: Engaged mode moves to locked when the count matches the multiple.
// R7: Bypass mode drives the output straight from the external clock.
// R8: Loop external mode targets a programmable multiple of the external reference.
// R9: Loop output confined between 8 MHz and 40 MHz.
// R10: Bus clock divider applies one of eight divisors, /1 to /128.
// R11: Loss of reference or lock raises reset or interrupt as configured.
// R12: Status shows lock achieved and lock lost.
// R13: External reference is monitored and its validity reported.
// R14: Oscillator setting is kept through stop for fast relock.
// R15: Oscillator keeps its frequency when the reference vanishes.
// R16: Switching to a clock source that is not running is refused.
// R17: Locked state is entered automatically; the loop output already drives the generator output before lock.
// R18: Outputs loop clock, reference clock, fixed frequency enable and debug clock.
// R19: An internal 8 MHz source may serve as debug local clock.
// R20: Slow 243 kHz internal reference takes a software trim.
// R21: Real-time interrupt gets its own self-clocked source.
// R22: Oscillator range and low-power or high-gain drive are software selectable.
// R23: Mode selector codes 00 self, 01 loop internal, 10 bypass, 11 loop external.
// R24: Bypass request waits until the external reference is active.
// R25: Gain, range and reference type accept only the first write after reset.
// R26: First write picking an internal mode locks out external modes until reset.
// R27: Clock source changes happen only while both clocks are low.
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module cgm_clock_generator
  import cgm_pkg::*;
#(
  parameter logic [13:0] REF_LOSS_CYCLES = 14'(REF_LOSS_CYC),
  parameter logic [17:0] RTI_HALF_CYCLES = 18'(RTI_CYC)
)
(
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire cgm_apb_req_t apb_req,
  output cgm_apb_rsp_t      apb_rsp,
  input  wire logic         ext_ref_in,
  input  wire logic         stop_req,
  output logic              generator_output_clock,
  output logic              loop_output_clock,
  output logic              external_reference_clock,
  output logic              fixed_freq_enable,
  output logic              debug_local_clock,
  output logic              bus_clock,
  output logic              rti_clock,
  output logic              osc_enable,
  output logic              osc_high_gain,
  output logic              osc_range,
  output logic              osc_ref_crystal,
  output logic              clock_fault_reset,
  output logic              clock_fault_irq
);

  typedef struct packed {
    logic          high_gain;
    logic          range;
    logic          ref_sel;
    logic [1:0]    mode_sel;
    logic          osc_stop_en;
    logic          loss_dis;
    logic          c1_written;
    logic          ext_lockout;
    logic [2:0]    bus_div;
    logic          dbg_fast;
    logic          loss_rst_en;
    logic [7:0]    mult;
    logic [15:0]   filter;
    logic [7:0]    trim;
    logic          lost_lock;
    logic          loss_clk;
    cgm_state_t    state;
    logic [15:0]   phase;
    logic          dco_q;
    logic          ext_q;
    logic [13:0]   ref_timer;
    logic          ref_ok;
    logic [10:0]   slow_cnt;
    logic [4:0]    fast_cnt;
    logic          fast_clk;
    logic          dbg_clk;
    logic [17:0]   rti_cnt;
    logic          rti_clk;
    logic [8:0]    edge_cnt;
    logic          primed;
    logic [3:0]    lock_cnt;
    logic          src_ext;
    logic          gen_clk;
    logic [6:0]    div_cnt;
    logic          bus_clk;
    logic          ffe;
    logic [31:0]   prdata;
    logic          pslverr;
  } cgm_regs_t;

  cgm_regs_t q_reg;
  cgm_regs_t q_next;

  localparam cgm_regs_t REGS_RESET = '{
    mode_sel: CGM_SEL_SELF,
    filter:   FILTER_RESET,
    trim:     TRIM_RESET,
    mult:     MULT_RESET,
    state:    CGM_SELF,
    default:  '0
  };

  // Combinational helpers
  logic        wr_acc;
  logic        rd_setup;
  logic        ext_rise;
  logic        dco_rise;
  logic        slow_tick;
  logic        ref_tick;
  logic        in_loop;
  logic        in_ext;
  logic        want_ext;
  logic [10:0] slow_period;
  logic [15:0] phase_sum;
  logic [15:0] filt_adj;
  logic [15:0] wfilt;
  logic [9:0]  cnt_w;
  logic [9:0]  mult_w;
  logic        too_slow;
  logic        too_fast;
  logic        lock_hit;
  logic        lock_miss;
  logic        loss_evt;
  logic        cur_lvl;
  logic        new_lvl;
  logic [7:0]  div_vec;
  logic [31:0] rd_val;
  logic        rd_hit;
  cgm_state_t  req_state;

  assign wr_acc    = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign rd_setup  = apb_req.psel & ~apb_req.penable;
  assign ext_rise  = ext_ref_in & ~q_reg.ext_q;
  assign phase_sum = q_reg.phase + q_reg.filter;
  assign dco_rise  = phase_sum[15] & ~q_reg.dco_q;
  assign in_ext    = (q_reg.state == CGM_BYPASS) | (q_reg.state == CGM_EXT_UNLK)
                   | (q_reg.state == CGM_EXT_LOCK);
  assign in_loop   = (q_reg.state == CGM_INT_UNLK) | (q_reg.state == CGM_INT_LOCK)
                   | (q_reg.state == CGM_EXT_UNLK) | (q_reg.state == CGM_EXT_LOCK);
  assign want_ext  = q_reg.mode_sel[1];

  // Trim shifts the slow reference period around its nominal value
  assign slow_period = 11'(SLOW_REF_CYC) + 11'(q_reg.trim) - 11'h080; // R20
  assign slow_tick   = (q_reg.slow_cnt >= slow_period - 11'h001);

  // Loop reference: slow internal or external edge
  assign ref_tick = ((q_reg.state == CGM_EXT_UNLK) | (q_reg.state == CGM_EXT_LOCK))
                  ? ext_rise : slow_tick; // R4 R8

  assign cnt_w     = {1'b0, q_reg.edge_cnt};
  assign mult_w    = {2'b00, q_reg.mult};
  assign too_slow  = (cnt_w + LOCK_TOL) < mult_w;
  assign too_fast  = cnt_w > (mult_w + LOCK_TOL);
  assign lock_hit  = in_loop & ref_tick & q_reg.primed & ~too_slow & ~too_fast;
  assign lock_miss = in_loop & ref_tick & q_reg.primed & (too_slow | too_fast);
  assign loss_evt  = in_ext & ~q_reg.loss_dis & q_reg.ref_ok
                   & (q_reg.ref_timer >= REF_LOSS_CYCLES - 14'h0001);

  // Adjust toward target, clamped to the loop range
  always_comb
  begin
    filt_adj = q_reg.filter;
    if (too_slow)
      filt_adj = q_reg.filter + FILTER_STEP; // R5
    else if (too_fast)
      filt_adj = q_reg.filter - FILTER_STEP; // R5
    if (filt_adj < FILTER_MIN)
      filt_adj = FILTER_MIN; // R9
    else if (filt_adj > FILTER_MAX)
      filt_adj = FILTER_MAX; // R9
    wfilt = apb_req.pwdata[15:0];
    if (wfilt < FILTER_MIN)
      wfilt = FILTER_MIN; // R9
    else if (wfilt > FILTER_MAX)
      wfilt = FILTER_MAX; // R9
  end

  // Requested operating state from the mode selector
  always_comb
  begin
    case (q_reg.mode_sel) // R23
      CGM_SEL_SELF:     req_state = CGM_SELF;
      CGM_SEL_LOOP_INT: req_state = CGM_INT_UNLK;
      CGM_SEL_BYPASS:   req_state = CGM_BYPASS;
      CGM_SEL_LOOP_EXT: req_state = CGM_EXT_UNLK;
      default:          req_state = CGM_SELF;
    endcase
  end

  // Register read mux
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (apb_req.paddr)
      CTRL1_OFFSET:
      begin
        rd_val[C1_HIGH_GAIN]              = q_reg.high_gain;
        rd_val[C1_RANGE]                  = q_reg.range;
        rd_val[C1_REF_SEL]                = q_reg.ref_sel;
        rd_val[C1_MODE_LSB +: 2]          = q_reg.mode_sel;
        rd_val[C1_OSC_STOP]               = q_reg.osc_stop_en;
        rd_val[C1_LOC_DIS]                = q_reg.loss_dis;
      end
      CTRL2_OFFSET:
      begin
        rd_val[C2_DIV_LSB +: 3]           = q_reg.bus_div;
        rd_val[C2_DBG_FAST]               = q_reg.dbg_fast;
        rd_val[C2_LOSS_RST]               = q_reg.loss_rst_en;
        rd_val[C2_MULT_LSB +: 8]          = q_reg.mult;
      end
      STATUS_OFFSET:
      begin
        rd_val[ST_LOCKED]    = (q_reg.state == CGM_INT_LOCK)
                             | (q_reg.state == CGM_EXT_LOCK); // R12
        rd_val[ST_LOST_LOCK] = q_reg.lost_lock; // R12
        rd_val[ST_LOSS_CLK]  = q_reg.loss_clk;
        rd_val[ST_REF_OK]    = q_reg.ref_ok; // R13
        rd_val[ST_STATE_LSB +: 3] = q_reg.state;
      end
      FILTER_OFFSET: rd_val[15:0] = q_reg.filter;
      TRIM_OFFSET:   rd_val[7:0]  = q_reg.trim;
      default:       rd_hit = 1'b0;
    endcase
  end

  // Glitch-free source switch levels
  assign cur_lvl = q_reg.src_ext ? q_reg.ext_q : q_reg.dco_q;
  assign new_lvl = (q_reg.state == CGM_BYPASS) ? q_reg.ext_q : q_reg.dco_q;
  assign div_vec = {q_reg.div_cnt, q_reg.gen_clk};

  always_comb
  begin
    q_next = q_reg;

    // APB setup phase captures read data and error
    if (rd_setup)
    begin
      q_next.prdata  = apb_req.pwrite ? 32'h0000_0000 : rd_val;
      q_next.pslverr = ~rd_hit;
    end

    // Oscillator keeps running; filter only changes by loop or software
    q_next.phase = phase_sum; // R3 R14 R15
    q_next.dco_q = phase_sum[15];
    q_next.ext_q = ext_ref_in;

    // External reference monitor
    if (ext_rise)
    begin
      q_next.ref_timer = '0;
      q_next.ref_ok    = 1'b1; // R13
    end
    else if (q_reg.ref_timer >= REF_LOSS_CYCLES - 14'h0001)
      q_next.ref_ok = 1'b0; // R13
    else
      q_next.ref_timer = q_reg.ref_timer + 14'h0001;

    // Internal references and the real-time interrupt source
    q_next.slow_cnt = slow_tick ? 11'h000 : q_reg.slow_cnt + 11'h001;
    if (q_reg.fast_cnt == 5'(FAST_REF_CYC - 1))
      q_next.fast_cnt = 5'h00;
    else
      q_next.fast_cnt = q_reg.fast_cnt + 5'h01;
    q_next.fast_clk = (q_next.fast_cnt < 5'(FAST_REF_CYC / 2)); // R19
    q_next.dbg_clk  = q_reg.dbg_fast ? q_reg.fast_clk : q_reg.dco_q; // R18 R19
    if (q_reg.rti_cnt >= RTI_HALF_CYCLES - 18'h00001)
    begin
      q_next.rti_cnt = '0;
      q_next.rti_clk = ~q_reg.rti_clk; // R21
    end
    else
      q_next.rti_cnt = q_reg.rti_cnt + 18'h00001;

    // Fixed frequency enable pulses once per reference period
    q_next.ffe = in_ext ? ext_rise : slow_tick; // R18

    // Loop frequency measurement
    if (!in_loop)
    begin
      q_next.edge_cnt = '0;
      q_next.primed   = 1'b0;
      q_next.lock_cnt = '0;
    end
    else if (ref_tick)
    begin
      q_next.edge_cnt = '0;
      q_next.primed   = 1'b1;
      if (q_reg.primed)
        q_next.filter = filt_adj; // R5
    end
    else if (dco_rise && q_reg.edge_cnt != 9'h1FF)
      q_next.edge_cnt = q_reg.edge_cnt + 9'h001;

    if (lock_miss)
      q_next.lock_cnt = '0;
    else if (lock_hit && q_reg.lock_cnt != LOCK_WINDOWS)
      q_next.lock_cnt = q_reg.lock_cnt + 4'h1;

    // Operating state
    case (q_reg.state)
      CGM_OFF:
        if (!stop_req)
          q_next.state = CGM_SELF;
      CGM_SELF, CGM_INT_UNLK, CGM_INT_LOCK, CGM_BYPASS, CGM_EXT_UNLK, CGM_EXT_LOCK:
      begin
        if (stop_req)
          q_next.state = CGM_OFF; // R2
        else if (loss_evt)
          q_next.state = CGM_SELF; // R11
        else if (q_reg.state != req_state
                 && !(q_reg.state == CGM_INT_LOCK && req_state == CGM_INT_UNLK)
                 && !(q_reg.state == CGM_EXT_LOCK && req_state == CGM_EXT_UNLK))
        begin
          if (!want_ext || q_reg.ref_ok)
            q_next.state = req_state; // R16 R24
        end
        else if ((q_reg.state == CGM_INT_UNLK || q_reg.state == CGM_EXT_UNLK)
                 && lock_hit && q_reg.lock_cnt == LOCK_WINDOWS - 4'h1)
          q_next.state = cgm_state_t'(q_reg.state + 3'b001); // R6 R17
        else if ((q_reg.state == CGM_INT_LOCK || q_reg.state == CGM_EXT_LOCK) && lock_miss)
          q_next.state = cgm_state_t'(q_reg.state - 3'b001); // R5
      end
      default: q_next.state = CGM_SELF;
    endcase
    if (q_reg.state == CGM_SELF && req_state == CGM_SELF)
      q_next.state = stop_req ? CGM_OFF : CGM_SELF;

    // Output source change only while both clocks sit low
    if (q_reg.src_ext != (q_reg.state == CGM_BYPASS) && !cur_lvl && !new_lvl)
      q_next.src_ext = (q_reg.state == CGM_BYPASS); // R27 R7
    if (q_reg.state == CGM_OFF)
      q_next.gen_clk = 1'b0; // R2
    else
      q_next.gen_clk = q_next.src_ext ? q_next.ext_q : q_next.dco_q; // R7

    // Bus divider counts generator rising edges
    if (q_next.gen_clk && !q_reg.gen_clk)
      q_next.div_cnt = q_reg.div_cnt + 7'h01; // R10
    q_next.bus_clk = div_vec[q_reg.bus_div]; // R10

    // Register writes
    if (wr_acc)
    begin
      case (apb_req.paddr)
        CTRL1_OFFSET:
        begin
          if (!q_reg.c1_written)
          begin
            q_next.high_gain   = apb_req.pwdata[C1_HIGH_GAIN]; // R25 R22
            q_next.range       = apb_req.pwdata[C1_RANGE]; // R25 R22
            q_next.ref_sel     = apb_req.pwdata[C1_REF_SEL]; // R25
            q_next.c1_written  = 1'b1;
            q_next.ext_lockout = ~apb_req.pwdata[C1_MODE_LSB + 1]; // R26
          end
          if (!(q_reg.ext_lockout || (!q_reg.c1_written && !apb_req.pwdata[C1_MODE_LSB + 1]))
              || !apb_req.pwdata[C1_MODE_LSB + 1])
            q_next.mode_sel = apb_req.pwdata[C1_MODE_LSB +: 2]; // R26
          q_next.osc_stop_en = apb_req.pwdata[C1_OSC_STOP];
          q_next.loss_dis    = apb_req.pwdata[C1_LOC_DIS];
        end
        CTRL2_OFFSET:
        begin
          q_next.bus_div     = apb_req.pwdata[C2_DIV_LSB +: 3];
          q_next.dbg_fast    = apb_req.pwdata[C2_DBG_FAST];
          q_next.loss_rst_en = apb_req.pwdata[C2_LOSS_RST];
          q_next.mult        = apb_req.pwdata[C2_MULT_LSB +: 8];
        end
        STATUS_OFFSET:
        begin
          if (apb_req.pwdata[ST_LOST_LOCK])
            q_next.lost_lock = 1'b0;
          if (apb_req.pwdata[ST_LOSS_CLK])
            q_next.loss_clk = 1'b0;
        end
        FILTER_OFFSET: q_next.filter = wfilt; // R3 R9
        TRIM_OFFSET:   q_next.trim   = apb_req.pwdata[7:0]; // R20
        default:       q_next.trim   = q_reg.trim;
      endcase
    end

    // Sticky fault flags, set wins over clear
    if (lock_miss && (q_reg.state == CGM_INT_LOCK || q_reg.state == CGM_EXT_LOCK))
      q_next.lost_lock = 1'b1; // R12 R11
    if (loss_evt)
      q_next.loss_clk = 1'b1; // R11
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      q_reg <= REGS_RESET; // R1
    else
      q_reg <= q_next;
  end

  assign apb_rsp.pready  = apb_req.psel & apb_req.penable;
  assign apb_rsp.pslverr = q_reg.pslverr & apb_req.psel & apb_req.penable;
  assign apb_rsp.prdata  = q_reg.prdata;

  assign generator_output_clock   = q_reg.gen_clk;
  assign loop_output_clock        = q_reg.dco_q; // R18
  assign external_reference_clock = q_reg.ext_q; // R18
  assign fixed_freq_enable        = q_reg.ffe;
  assign debug_local_clock        = q_reg.dbg_clk;
  assign bus_clock                = q_reg.bus_clk;
  assign rti_clock                = q_reg.rti_clk;
  assign osc_enable               = q_reg.c1_written & ~q_reg.ext_lockout
                                  & ((q_reg.state != CGM_OFF) | q_reg.osc_stop_en);
  assign osc_high_gain            = q_reg.high_gain; // R22
  assign osc_range                = q_reg.range; // R22
  assign osc_ref_crystal          = q_reg.ref_sel;
  assign clock_fault_reset        = (q_reg.lost_lock | q_reg.loss_clk) & q_reg.loss_rst_en; // R11
  assign clock_fault_irq          = (q_reg.lost_lock | q_reg.loss_clk) & ~q_reg.loss_rst_en; // R11

endmodule : cgm_clock_generator

`default_nettype wire

// *** test/cgm_ref_source.sv ***
// External reference clock source model
`timescale 1ns/1ps
`default_nettype none
module cgm_ref_source
#(
  parameter int HALF = 100
)
(
  input  wire logic sys_clk,
  input  wire logic run,
  output logic      ref_out
);
  int cnt;
  initial ref_out = 1'b0;
  // Removed source stands low
  always @(posedge sys_clk)
  begin
    cnt <= (!run || cnt == HALF - 1) ? 0 : cnt + 1;
    if (!run)
      ref_out <= 1'b0;
    else if (cnt == HALF - 1)
      ref_out <= ~ref_out;
  end
endmodule : cgm_ref_source
`default_nettype wire

// *** test/cgm_clock_generator_properties.sv ***
// Concurrent checks on the clock generator ports
`timescale 1ns/1ps
`default_nettype none
module cgm_props
  import cgm_pkg::*;
#(
  parameter logic [13:0] REF_LOSS_CYCLES = 14'h0040,
  parameter logic [17:0] RTI_HALF_CYCLES = 18'h00008
)
(
  input wire logic         sys_clk,
  input wire logic         reset,
  input wire cgm_apb_req_t apb_req,
  input wire cgm_apb_rsp_t apb_rsp,
  input wire logic         ext_ref_in,
  input wire logic         stop_req,
  input wire logic         generator_output_clock,
  input wire logic         external_reference_clock,
  input wire logic         fixed_freq_enable,
  input wire logic         debug_local_clock,
  input wire logic         rti_clock,
  input wire logic         osc_high_gain,
  input wire logic         osc_range,
  input wire logic         osc_ref_crystal,
  input wire logic         clock_fault_reset,
  input wire logic         clock_fault_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic        c1_done;
  logic        rti_seen;
  logic [17:0] rti_cnt;
  logic [5:0]  stop_cnt;
  wire logic   c1_wr = apb_req.psel && apb_req.penable && apb_req.pwrite
                       && apb_req.paddr == CTRL1_OFFSET && apb_rsp.pready;
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      c1_done  <= 1'b0;
      rti_seen <= 1'b0;
      rti_cnt  <= 18'h00000;
      stop_cnt <= 6'h00;
    end
    else
    begin
      c1_done  <= c1_done | c1_wr;
      rti_seen <= rti_seen | $changed(rti_clock);
      rti_cnt  <= $changed(rti_clock) ? 18'h00000 : rti_cnt + 18'h00001;
      stop_cnt <= !stop_req ? 6'h00 : (stop_cnt == 6'h3F ? stop_cnt : stop_cnt + 6'h01);
    end
  end
  property p_self_start;
    $fell(reset) |-> ##[1:64] $changed(generator_output_clock);
  endproperty
  a_self_start: assert property (p_self_start) else $error("no clock after reset");
  property p_stop_static;
    stop_cnt >= 6'h20 |-> !generator_output_clock;
  endproperty
  a_stop_static: assert property (p_stop_static) else $error("clock runs in off");
  property p_fault_excl;
    !(clock_fault_reset && clock_fault_irq);
  endproperty
  a_fault_excl: assert property (p_fault_excl) else $error("reset and irq together");
  property p_ref_follow;
    $rose(ext_ref_in) |=> $rose(external_reference_clock);
  endproperty
  a_ref_follow: assert property (p_ref_follow) else $error("reference not routed");
  property p_ffe_pulse;
    fixed_freq_enable |=> !fixed_freq_enable;
  endproperty
  a_ffe_pulse: assert property (p_ffe_pulse) else $error("enable wider than one cycle");
  property p_rti_period;
    rti_seen && $changed(rti_clock) |-> rti_cnt == RTI_HALF_CYCLES - 18'h00001;
  endproperty
  a_rti_period: assert property (p_rti_period) else $error("rti half period wrong");
  property p_dbg_runs;
    disable iff (reset || stop_req)
    $changed(debug_local_clock) |-> ##[1:40] $changed(debug_local_clock);
  endproperty
  a_dbg_runs: assert property (p_dbg_runs) else $error("debug clock stalled");
  property p_write_once;
    c1_done && c1_wr |=> $stable({osc_high_gain, osc_range, osc_ref_crystal});
  endproperty
  a_write_once: assert property (p_write_once) else $error("oscillator config rewritten");
  property p_err_access;
    apb_rsp.pslverr |-> apb_req.psel && apb_req.penable && apb_rsp.pready;
  endproperty
  a_err_access: assert property (p_err_access) else $error("error outside access");
endmodule : cgm_props
bind cgm_clock_generator cgm_props #(
  .REF_LOSS_CYCLES(REF_LOSS_CYCLES),
  .RTI_HALF_CYCLES(RTI_HALF_CYCLES)
) i_cgm_props (.sys_clk(sys_clk), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .ext_ref_in(ext_ref_in), .stop_req(stop_req), .generator_output_clock(generator_output_clock),
  .external_reference_clock(external_reference_clock), .fixed_freq_enable(fixed_freq_enable),
  .debug_local_clock(debug_local_clock), .rti_clock(rti_clock), .osc_high_gain(osc_high_gain),
  .osc_range(osc_range), .osc_ref_crystal(osc_ref_crystal),
  .clock_fault_reset(clock_fault_reset), .clock_fault_irq(clock_fault_irq));
`default_nettype wire

// *** test/testbench.sv ***
// Testbench for the clock generator mode control
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin fails++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, x); end end
module testbench
  import cgm_pkg::*;
;
  logic         sys_clk, reset, ext_ref_in, stop_req, run, gen_clk, irq, rst_out, hg, rg, rc, e;
  logic         bc, oe, lc, lp;
  cgm_apb_req_t req;
  cgm_apb_rsp_t rsp;
  logic [31:0]  d;
  int           fails, compares, cycles, n;
  cgm_clock_generator #(.REF_LOSS_CYCLES(14'h0040), .RTI_HALF_CYCLES(18'h00008))
  i_cgm_clock_generator (.sys_clk(sys_clk), .reset(reset), .apb_req(req), .apb_rsp(rsp),
    .ext_ref_in(ext_ref_in), .stop_req(stop_req), .generator_output_clock(gen_clk),
    .loop_output_clock(lc), .external_reference_clock(), .fixed_freq_enable(),
    .debug_local_clock(), .bus_clock(bc), .rti_clock(), .osc_enable(oe), .osc_high_gain(hg),
    .osc_range(rg), .osc_ref_crystal(rc), .clock_fault_reset(rst_out), .clock_fault_irq(irq));
  cgm_ref_source #(.HALF(20)) i_cgm_ref_source (.sys_clk(sys_clk), .run(run),
    .ref_out(ext_ref_in));
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic complete_run;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fails++;
      complete_run();
    end
  end
  // One APB transfer; read data and error land in d and e
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do @(posedge sys_clk); while (rsp.pready !== 1'b1);
    d = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask : apb
  task automatic wait_state(input logic [2:0] s);
    for (int i = 0; i < 8000; i++)
    begin
      apb(1'b0, STATUS_OFFSET, 32'h0);
      if (d[10:8] === s)
        break;
    end
    `CHK(d[10:8], s)
  endtask : wait_state
  task automatic do_reset;
    reset <= 1'b1;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
  endtask : do_reset
  initial
  begin
    req = '0;
    reset = 1'b1;
    run = 1'b0;
    stop_req = 1'b0;
    do_reset();
    apb(1'b0, STATUS_OFFSET, 32'h0);
    `CHK(d[10:8], 3'h1)
    apb(1'b1, CTRL2_OFFSET, 32'h0000_4001);
    repeat (2) @(posedge sys_clk);
    @(posedge bc);
    @(posedge gen_clk);
    repeat (2) @(negedge sys_clk);
    `CHK(bc, 1'b0)
    @(posedge gen_clk);
    repeat (2) @(negedge sys_clk);
    `CHK(bc, 1'b1)
    apb(1'b1, CTRL1_OFFSET, 32'hE0);
    @(negedge sys_clk);
    `CHK({hg, rg, rc, oe}, 4'hE)
    apb(1'b1, CTRL1_OFFSET, 32'h08);
    apb(1'b1, CTRL1_OFFSET, 32'h18);
    @(negedge sys_clk);
    `CHK({hg, rg, rc}, 3'h7)
    apb(1'b0, CTRL1_OFFSET, 32'h0);
    `CHK(d[4:3], 2'h1)
    apb(1'b1, FILTER_OFFSET, 32'h13E8);
    wait_state(3'h3);
    `CHK(d[ST_LOCKED], 1'b1)
    stop_req <= 1'b1;
    repeat (40) @(posedge sys_clk);
    n = 0;
    lp = lc;
    repeat (16)
    begin
      @(negedge sys_clk);
      `CHK(gen_clk, 1'b0)
      n += int'(lc != lp);
      lp = lc;
    end
    `CHK(n >= 2, 1'b1)
    @(posedge sys_clk);
    stop_req <= 1'b0;
    do_reset();
    apb(1'b1, CTRL1_OFFSET, 32'h10);
    @(negedge sys_clk);
    `CHK(oe, 1'b1)
    repeat (20) @(posedge sys_clk);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    `CHK(d[10:8], 3'h1)
    run <= 1'b1;
    wait_state(3'h4);
    `CHK(d[ST_REF_OK], 1'b1)
    run <= 1'b0;
    repeat (400) @(posedge sys_clk);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    `CHK({irq, rst_out, d[ST_LOSS_CLK], d[10:8]}, 6'h29)
    apb(1'b1, STATUS_OFFSET, 32'h4);
    @(negedge sys_clk);
    `CHK(irq, 1'b0)
    apb(1'b0, 8'h20, 32'h0);
    `CHK({e, d}, 33'h100000000)
    apb(1'b1, FILTER_OFFSET, 32'h1999);
    apb(1'b1, CTRL2_OFFSET, 32'h0000_0400);
    apb(1'b1, CTRL1_OFFSET, 32'h18);
    run <= 1'b1;
    wait_state(3'h6);
    repeat (200) @(posedge sys_clk);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    `CHK({d[ST_LOCKED], d[10:8]}, 4'hE)
    complete_run();
  end
endmodule : testbench
`default_nettype wire
